//--- core/vcs_regs.vh
// Purpose: Constants for the VRAM bank and channel strobe selector
// Assumes: 100 MHz frame buffer clock
// Notes: Definitions only; included by bare name
`ifndef VCS_REGS_VH
`define VCS_REGS_VH

// Clock rate and strobe phase times
`define VCS_CLK_MHZ 100
`define VCS_T_RAS_NS 60
`define VCS_T_CAS_NS 30
// Least times round up to whole cycles
`define VCS_RAS_CYC ((`VCS_T_RAS_NS * `VCS_CLK_MHZ + 999) / 1000)
`define VCS_CAS_CYC ((`VCS_T_CAS_NS * `VCS_CLK_MHZ + 999) / 1000)

// Access mode codes on the mode outputs; 2'b11 is idle and reset level
`define VCS_MODE_HORIZ 2'h0
`define VCS_MODE_DIAG 2'h1
`define VCS_MODE_BCAST 2'h2
`define VCS_MODE_IDLE 2'h3

// Cycle kinds on the request port
`define VCS_CYC_DATA 2'h0
`define VCS_CYC_REFRESH 2'h1
`define VCS_CYC_XFER 2'h2
`define VCS_CYC_PMASK 2'h3

// Reset levels of the strobe outputs
`define VCS_RST_CAS 4'hf
`define VCS_RST_CASEN 2'h3
`define VCS_RST_RAS 4'hf
`define VCS_RST_RASEN 4'h0

`endif

//--- core/vcs_mode_decode.v
// Purpose: Pick access mode and per-request RAS enable and bank select
// Assumes: Request fields stable while sampled
// Notes: Purely combinational; registered by the caller
`timescale 1ns/1ps
`default_nettype none
`include "vcs_regs.vh"

module vcs_mode_decode (
  input wire deep32,
  input wire [1:0] cycleKind,
  input wire unpacked8,
  input wire segment,
  input wire [1:0] bank,
  output reg [1:0] modeCode,
  output reg [3:0] rasEnableN,
  output reg [1:0] bankSelect
);

  // One-hot bank decode, active low
  function [3:0] bankLowHot;
    input [1:0] b;
    begin
      bankLowHot = ~(4'h1 << b);
    end
  endfunction

  // Mode, RAS enables and bank select from the request
  always @* begin
    modeCode = `VCS_MODE_HORIZ;
    rasEnableN = 4'hf;
    bankSelect = bank;
    if (cycleKind != `VCS_CYC_DATA) begin
      // RULE_09: broadcast to whole segment
      modeCode = `VCS_MODE_BCAST;
      bankSelect = 2'h3;
    end else if (deep32 && unpacked8) begin
      // RULE_11: diagonal for unpacked 8-bpp
      // RULE_10: bytes from eight dwords
      modeCode = `VCS_MODE_DIAG;
    end
    if (deep32) begin
      // RULE_06: whole segment RAS enable
      rasEnableN = segment ? 4'h3 : 4'hc;
    end else begin
      // RULE_04: one bank per segment for data cycles; all four banks for other cycles
      rasEnableN = (cycleKind != `VCS_CYC_DATA) ? 4'h0 : bankLowHot(bank);
    end
  end

endmodule // vcs_mode_decode

`default_nettype wire

//--- core/vcs_strobe_select.v
// Purpose: Sequence RAS and CAS strobe selection toward the external decoder
// Assumes: Requests synchronous to clk; one request at a time
// Notes: Outputs registered; the decoder turns them into per-bank strobes

`timescale 1ns/1ps
`default_nettype none
`include "vcs_regs.vh"

// Function
// RULE_01: 8-plane uses one segment, four banks
// RULE_02: 32-plane uses two segments of banks
// RULE_03: 8-bpp channel strobes pick channel-bank
// RULE_04: 8-bpp RAS enable one bank only; the code enables all four banks for refresh, transfer and plane-mask cycles
// RULE_05: Decoder lets RAS-enabled bank answer CAS
// RULE_06: 32-bpp enables RAS for whole segment
// RULE_07: 32-bpp bank enables identify answering bank
// RULE_08: Horizontal mode moves two dwords, one bank
// RULE_09: Broadcast for refresh, transfers, plane masks
// RULE_10: Diagonal takes one byte per dword
// RULE_11: Diagonal for unpacked 8-bpp, else horizontal
// RULE_12: Mode code driven on mode outputs
// RULE_13: Decoder builds sixteen strobes per segment
// RULE_14: Reset holds CAS, bank, mode high
// RULE_15: Reset holds RAS high, enables low
// RULE_16: Fixed two-bit mode code assignment
module vcs_strobe_select #(
  parameter RAS_CYC = `VCS_RAS_CYC,
  parameter CAS_CYC = `VCS_CAS_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire deep32,
  input wire reqValid,
  input wire [1:0] reqCycle,
  input wire reqUnpacked8,
  input wire reqSegment,
  input wire [1:0] reqBank,
  input wire [3:0] reqChannels,
  output reg reqReady_q,
  output reg [3:0] rasData_n_q,
  output reg [3:0] rasEnable_n_q,
  output reg [3:0] casStrobe_n_q,
  output reg [1:0] casBankEnable_q,
  output reg [1:0] casModeCode_q
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RAS = 2'h1;
  localparam [1:0] ST_CAS = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;
  // Cut to counter width on purpose; 256 wraps to 8'hff as intended
  localparam [7:0] RAS_LAST = RAS_CYC[7:0] - 8'h1;
  localparam [7:0] CAS_LAST = CAS_CYC[7:0] - 8'h1;

  reg [1:0] state_q;
  reg [7:0] count_q;
  reg cbr_q;
  reg [3:0] chans_q;
  reg segment_q;
  wire [1:0] modeCode;
  wire [3:0] rasEnableN;
  wire [1:0] bankSelect;
  // 8-plane has a single segment, so the segment field is forced low
  // RULE_01: one segment when shallow
  wire segEff = deep32 & reqSegment;
  wire take = reqValid & reqReady_q;

  vcs_mode_decode u_decode (
    .deep32(deep32),
    .cycleKind(reqCycle),
    .unpacked8(reqUnpacked8),
    .segment(segEff),
    .bank(reqBank),
    .modeCode(modeCode),
    .rasEnableN(rasEnableN),
    .bankSelect(bankSelect)
  );

  // Strobe sequencer; refresh runs CAS before RAS
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      count_q <= 8'h0;
      cbr_q <= 1'b0;
      chans_q <= 4'h0;
      segment_q <= 1'b0;
      reqReady_q <= 1'b0;
      // RULE_14: strobes and mode high
      casStrobe_n_q <= `VCS_RST_CAS;
      casBankEnable_q <= `VCS_RST_CASEN;
      casModeCode_q <= `VCS_MODE_IDLE;
      // RULE_15: RAS high, enables low
      rasData_n_q <= `VCS_RST_RAS;
      rasEnable_n_q <= `VCS_RST_RASEN;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          reqReady_q <= 1'b1;
          if (take) begin
            reqReady_q <= 1'b0;
            cbr_q <= (reqCycle == `VCS_CYC_REFRESH);
            chans_q <= reqChannels;
            segment_q <= segEff;
            // RULE_12: present access mode
            // RULE_16: fixed code assignment
            casModeCode_q <= modeCode;
            // RULE_07: bank select with strobe
            // RULE_08: horizontal targets one bank
            casBankEnable_q <= bankSelect;
            rasEnable_n_q <= rasEnableN;
            count_q <= 8'h0;
            state_q <= ST_RAS;
            if (reqCycle == `VCS_CYC_REFRESH) begin
              // Refresh: CAS leads RAS on all channels
              casStrobe_n_q <= 4'h0;
            end else begin
              rasData_n_q <= segEff ? 4'h3 : 4'hc;
            end
          end
        end
        ST_RAS: begin
          count_q <= count_q + 8'h1;
          if (count_q == RAS_LAST) begin
            count_q <= 8'h0;
            state_q <= ST_CAS;
            if (cbr_q) begin
              rasData_n_q <= segment_q ? 4'h3 : 4'hc;
            end else begin
              // RULE_03: channel strobes select channel
              casStrobe_n_q <= ~chans_q;
            end
          end
        end
        ST_CAS: begin
          count_q <= count_q + 8'h1;
          if (count_q == CAS_LAST) begin
            state_q <= ST_DONE;
          end
        end
        default: begin
          // Release all strobes; at least two idle cycles give precharge
          casStrobe_n_q <= 4'hf;
          rasData_n_q <= 4'hf;
          casModeCode_q <= `VCS_MODE_IDLE;
          casBankEnable_q <= 2'h3;
          rasEnable_n_q <= 4'hf;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // vcs_strobe_select

`default_nettype wire

//--- bench/vcs_chk_monitor.sv
// Purpose: Port checks
// Assumes: Header mode codes
// Notes: Bound below
`timescale 1ns/1ps
`default_nettype none
`include "vcs_regs.vh"
module vcs_chk_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic deep32,
  input wire logic reqValid,
  input wire logic [1:0] reqCycle,
  input wire logic reqUnpacked8,
  input wire logic reqSegment,
  input wire logic [1:0] reqBank,
  input wire logic [3:0] reqChannels,
  input wire logic reqReady_q,
  input wire logic [3:0] rasEnable_n_q,
  input wire logic [3:0] casStrobe_n_q,
  input wire logic [1:0] casBankEnable_q,
  input wire logic [1:0] casModeCode_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] chan_q;
  wire tk = reqValid && reqReady_q && clkEn;
  wire dat = reqCycle == `VCS_CYC_DATA;
  // Channels kept, strobes come much later
  always @(posedge clk) if (tk) chan_q <= reqChannels;
  diag_mode_a: assert property (
    tk && dat && deep32 && reqUnpacked8 |=> casModeCode_q == `VCS_MODE_DIAG) else $error("diag");
  horiz_bank_a: assert property (
    tk && dat && !(deep32 && reqUnpacked8) |=> casModeCode_q == 0 && casBankEnable_q == $past(reqBank))
    else $error("horiz");
  bcast_mode_a: assert property (
    tk && !dat |=> casModeCode_q == `VCS_MODE_BCAST && casBankEnable_q == 2'h3) else $error("bcast");
  refresh_cas_a: assert property (
    tk && reqCycle == 1 |=> casStrobe_n_q == 4'h0) else $error("refresh");
  ras_one_a: assert property (
    tk && dat && !deep32 |=> rasEnable_n_q == ~(4'h1 << $past(reqBank))) else $error("ras one");
  ras_seg_a: assert property (
    tk && deep32 |=> rasEnable_n_q == ($past(reqSegment) ? 4'h3 : 4'hc)) else $error("ras seg");
  cas_chan_a: assert property (
    casModeCode_q != 2 && casStrobe_n_q != 4'hf |-> casStrobe_n_q == ~chan_q) else $error("cas");
  reset_hold_a: assert property (
    disable iff (1'b0) !rst_n ##1 !rst_n |-> casStrobe_n_q == 4'hf && casBankEnable_q == 2'h3
    && casModeCode_q == 2'h3 && rasEnable_n_q == 4'h0) else $error("reset");
endmodule // vcs_chk_monitor
bind vcs_strobe_select vcs_chk_monitor mon (.clk, .rst_n, .clkEn, .deep32, .reqValid, .reqCycle,
  .reqUnpacked8, .reqSegment, .reqBank, .reqChannels, .reqReady_q, .rasEnable_n_q, .casStrobe_n_q,
  .casBankEnable_q, .casModeCode_q);
`default_nettype wire

//--- bench/vcs_far_decoder.sv
// Purpose: Far-side strobe decoder
// Assumes: Header mode codes
// Notes: Bit 4*bank+channel
`timescale 1ns/1ps
`default_nettype none
`include "vcs_regs.vh"
module vcs_far_decoder (
  input wire logic deep32,
  input wire logic [3:0] rasEn_n,
  input wire logic [3:0] cas_n,
  input wire logic [1:0] casEn,
  input wire logic [1:0] mode,
  output var logic [15:0] bankCas_n
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      bankCas_n[i] = cas_n[i % 4] | (!deep32 ? rasEn_n[i / 4] : mode == `VCS_MODE_BCAST ? 1'b0
        : (mode == `VCS_MODE_DIAG ? (casEn + i) % 4 : casEn) != i / 4);
    end
  end
endmodule // vcs_far_decoder
`default_nettype wire

//--- bench/test_vcs_strobe_select.sv
// Purpose: Strobe selector bench
// Assumes: clkEn random
// Notes: Driver queues notes
`timescale 1ns/1ps
`default_nettype none
`include "vcs_regs.vh"
module test_vcs_strobe_select;
  logic clk = 0, rst_n = 0, clkEn = 1, deep32 = 0, reqValid = 0, reqUnpacked8 = 0, reqSegment = 0;
  logic [1:0] reqCycle = 0, reqBank = 0, casBankEnable_q, casModeCode_q;
  logic [3:0] reqChannels = 0, rasData_n_q, rasEnable_n_q, casStrobe_n_q;
  logic reqReady_q;
  logic [15:0] bankCas_n;
  logic [7:0] expQ[$];
  logic [15:0] expS[$];
  logic [3:0] lastCas = 4'hf;
  int mismatches = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  vcs_strobe_select dut (.clk, .rst_n, .clkEn, .deep32, .reqValid, .reqCycle, .reqUnpacked8,
    .reqSegment, .reqBank, .reqChannels, .reqReady_q, .rasData_n_q, .rasEnable_n_q,
    .casStrobe_n_q, .casBankEnable_q, .casModeCode_q);
  vcs_far_decoder far (.deep32, .rasEn_n(rasEnable_n_q), .cas_n(casStrobe_n_q),
    .casEn(casBankEnable_q), .mode(casModeCode_q), .bankCas_n);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  // Frozen phases and a hang limit
  always @(posedge clk) begin
    clkEn <= #1 ($urandom % 4 != 0);
    if (++cycles > 9000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Fields change only while idle
  task automatic send(input logic d, input logic [1:0] c, input logic u, input logic s, input logic [1:0] b);
    logic [3:0] ch;
    logic [15:0] e;
    while (reqReady_q !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    ch = 4'($urandom);
    // Per channel-bank strobe by rule: refresh hits all channels, broadcast all banks
    for (int k = 0; k < 16; k++) begin
      e[k] = !((c == 1 || ch[k % 4]) && (c != 0 || (d && u ? (b + k) % 4 == k / 4 : b == k / 4)));
    end
    expQ.push_back({c != 0 ? 2'h2 : {1'b0, d && u}, c != 0 ? 2'h3 : b,
      d ? (s ? 4'h3 : 4'hc) : (c != 0 ? 4'h0 : ~(4'h1 << b))});
    // Outside refresh no channel strobe drops without channels, so no note then
    if (c == 1 || ch != 0) expS.push_back(e);
    {deep32, reqCycle, reqUnpacked8, reqSegment, reqBank} = {d, c, u, s, b};
    reqChannels = ch;
    reqValid = 1;
    @(posedge clk);
    while (clkEn !== 1'b1) @(posedge clk);
    #1 reqValid = 0;
  endtask
  // Oldest note against the take result
  always @(negedge reqReady_q) begin
    if (rst_n === 1'b1 && expQ.size() > 0) begin
      #1 cmp8("mode bank rasen", expQ.pop_front(), {casModeCode_q, casBankEnable_q, rasEnable_n_q});
    end
  end
  // Far-side strobes checked when the channel strobes first drop
  always @(posedge clk) begin
    #2;
    if (rst_n === 1'b1 && lastCas === 4'hf && casStrobe_n_q !== 4'hf && expS.size() > 0) begin
      cmp16("bank strobes", expS.pop_front(), bankCas_n);
    end
    lastCas = casStrobe_n_q;
  end
  initial begin
    void'($urandom(12));
    repeat (20) @(posedge clk);
    cmp8("reset", 8'hff, {casStrobe_n_q, rasData_n_q});
    #1 rst_n = 1;
    // Every kind in both layouts first
    for (int i = 0; i < 40; i++) begin
      send(i < 8 ? i[2] : 1'($urandom), i < 8 ? i[1:0] : 2'($urandom), 1'($urandom), 1'($urandom), 2'(i));
    end
    repeat (30) @(posedge clk);
    report_and_stop();
  end
endmodule // test_vcs_strobe_select
`default_nettype wire
